/* File: logic/bgr_defines.svh */
`ifndef BGR_DEFINES_SVH
`define BGR_DEFINES_SVH

`define BGR_OFS_EXP_ID 13'h0000
`define BGR_OFS_EXP_LAMP 13'h0002
`define BGR_OFS_SLOT_IDS_LO 16'h0000
`define BGR_OFS_SLOT_IDS_HI 16'h1000
`define BGR_OFS_SLOT_LAMPS 16'h2000
`define BGR_OFS_FABRIC 16'h3000
`define BGR_OFS_GLUE_VER 8'h00
`define BGR_OFS_CACHE_CTL 8'h01
`define BGR_EXP_ABSENT 8'hff
`define BGR_CARD_ABSENT 4'hf
`define BGR_LAMP_RST 8'h00
`define BGR_CACHE_RST 4'h0
`define BGR_FIELD_MASK_LAMP 8'h03
`define BGR_FIELD_MASK_CACHE 8'h0f
`define BGR_CACHE_REFILL_BIT 0
`define BGR_CACHE_WIPE_BIT 1
`define BGR_CACHE_DRAIN_BIT 2
`define BGR_CACHE_BYPASS_BIT 3

`endif

/* File: logic/bgr_pkg.sv */
package bgr_pkg;
    typedef struct packed {
        logic [3:0] slot0;
        logic [3:0] slot1;
        logic [3:0] slot2;
        logic [3:0] slot3;
    } bgr_card_ids_t;

    typedef struct packed {
        logic refill_block_n;
        logic directory_wipe_n;
        logic drain_n;
        logic force_bypass_n;
    } bgr_cache_ctl_t;

    typedef enum logic [1:0] {
        BGR_LAMP_OFF = 2'h0,
        BGR_LAMP_RED = 2'h1,
        BGR_LAMP_GREEN = 2'h2,
        BGR_LAMP_OFF2 = 2'h3
    } bgr_lamp_t;
endpackage

/* File: logic/bgr_lamp_drv.sv */
`timescale 1ns/10ps
// decodes one two-bit lamp code into registered red and green drives
module bgr_lamp_drv (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [1:0] code,
    output logic red,
    output logic green
);
    wire logic red_d;
    wire logic green_d;

    assign red_d = (code == bgr_pkg::BGR_LAMP_RED);
    assign green_d = (code == bgr_pkg::BGR_LAMP_GREEN);

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            red <= 1'b0;
            green <= 1'b0;
        end else begin
            red <= red_d;
            green <= green_d;
        end
    end
endmodule

/* File: logic/bgr_glue_regs.sv */
`timescale 1ns/10ps
`include "bgr_defines.svh"

// Function
// R1: expansion window offset 0x00 reads module identifier, 0xFF when absent.
// R2: expansion offset 0x02 bits 1:0 lamp code: 00/11 off, 01 red, 10 green.
// R3: peripheral 0x0000 gives slot1 low, slot0 high; 0x1000 slot3 low, slot2 high.
// R4: software treats card id 0xE as extended and reads slot offset 0.
// R5: a slot with no card reports identifier 0xF.
// R6: peripheral 0x2000 holds four lamp fields, slot3 lowest to slot0 highest.
// R7: peripheral 0x3000 is reserved, reads zero, ignores writes.
// R8: glue offset 0x00 reads the eight-bit version number.
// R9: glue offset 0x01 drives four active-low cache controls directly.
// R10: bit 0 resets to 0; while 0 refills are blocked.
// R11: bit 1 resets to 0; while 0 the cache directory is wiped.
// R12: bit 2 resets to 0; while 0 the cache is drained.
// R13: bit 3 resets to 0; while 0 every cache access misses.
// R14: software prepares the processor before enabling the cache.
// R15: unused cache control and expansion lamp bits read 0, ignore writes.
// R16: byte registers answer only under their window select, low address picks.
module bgr_glue_regs #(
    parameter logic [7:0] GLUE_VERSION = 8'h01 // arbitrary value
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic EXPANSION_WINDOW_SELECT_N,
    input wire logic PERIPHERAL_WINDOW_SELECT_N,
    input wire logic GLUE_WINDOW_SELECT_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RDATA_OE,
    input wire logic EXP_MODULE_PRESENT_N,
    input wire logic [7:0] EXP_MODULE_ID,
    input wire logic [3:0] CARD_PRESENT_N,
    input wire logic [15:0] CARD_IDS,
    output logic EXP_LAMP_RED,
    output logic EXP_LAMP_GREEN,
    output logic [3:0] SLOT_LAMP_RED,
    output logic [3:0] SLOT_LAMP_GREEN,
    output logic CACHE_REFILL_BLOCK_OUT_N,
    output logic CACHE_DIRECTORY_WIPE_OUT_N,
    output logic CACHE_DRAIN_OUT_N,
    output logic CACHE_FORCE_BYPASS_OUT_N
);
    // all bus pins come from the processor clock domain at board level, but the
    // pins are still synchronised; the bus must hold strobes for three clocks
    logic [2:0] sel_s1_q;
    logic [2:0] sel_s2_q;
    logic [1:0] str_s1_q;
    logic [1:0] str_s2_q;
    logic wr_seen_q;
    logic [15:0] addr_s1_q;
    logic [15:0] addr_s2_q;
    logic [7:0] wdat_s1_q;
    logic [7:0] wdat_s2_q;
    logic [8:0] exp_s1_q;
    logic [8:0] exp_s2_q;
    logic [19:0] card_s1_q;
    logic [19:0] card_s2_q;
    logic [1:0] exp_lamp_q;
    logic [7:0] slot_lamp_q;
    logic [3:0] cache_q;
    logic [7:0] rdata_q;
    logic rd_oe_q;

    bgr_pkg::bgr_card_ids_t ids;
    bgr_pkg::bgr_cache_ctl_t cache_out;

    function automatic logic [3:0] card_id(input logic absent_n, input logic [3:0] id);
        card_id = absent_n ? `BGR_CARD_ABSENT : id;
    endfunction

    function automatic logic [1:0] wdata_lamp(input logic [7:0] d);
        wdata_lamp = d[1:0] & 2'(`BGR_FIELD_MASK_LAMP);
    endfunction

    // selects reset inactive so no access is seen while reset releases
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            sel_s1_q <= 3'h7;
            sel_s2_q <= 3'h7;
        end else begin
            sel_s1_q <= {GLUE_WINDOW_SELECT_N, PERIPHERAL_WINDOW_SELECT_N,
                         EXPANSION_WINDOW_SELECT_N};
            sel_s2_q <= sel_s1_q;
        end
    end

    // strobes reset high, the idle level of the pins
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            str_s1_q <= 2'h3;
            str_s2_q <= 2'h3;
        end else begin
            str_s1_q <= {WR_N, RD_N};
            str_s2_q <= str_s1_q;
        end
    end

    // address is a multi-bit crossing; safe only because the bus holds it
    // stable for longer than the strobe path takes
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            addr_s1_q <= 16'h0000;
            addr_s2_q <= 16'h0000;
        end else begin
            addr_s1_q <= ADDR;
            addr_s2_q <= addr_s1_q;
        end
    end

    // write data rides with the address under the same hold rule
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wdat_s1_q <= 8'h00;
            wdat_s2_q <= 8'h00;
        end else begin
            wdat_s1_q <= WDATA;
            wdat_s2_q <= wdat_s1_q;
        end
    end

    // expansion module presence and id; reset reads as absent
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            exp_s1_q <= 9'h1ff;
            exp_s2_q <= 9'h1ff;
        end else begin
            exp_s1_q <= {EXP_MODULE_PRESENT_N, EXP_MODULE_ID};
            exp_s2_q <= exp_s1_q;
        end
    end

    // slot presence and ids; a card plugged mid-read may show a mixed id once
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            card_s1_q <= 20'hfffff;
            card_s2_q <= 20'hfffff;
        end else begin
            card_s1_q <= {CARD_PRESENT_N, CARD_IDS};
            card_s2_q <= card_s1_q;
        end
    end

    wire logic exp_sel = !sel_s2_q[0]; // R16
    wire logic per_sel = !sel_s2_q[1]; // R16
    wire logic glue_sel = !sel_s2_q[2]; // R16
    wire logic rd_act = !str_s2_q[0];
    wire logic wr_act = !str_s2_q[1];
    // one write per strobe, so a long low strobe does not rewrite
    wire logic wr_pulse = wr_act && !wr_seen_q;

    wire logic hit_exp_id = exp_sel && (addr_s2_q[12:0] == `BGR_OFS_EXP_ID);
    wire logic hit_exp_lamp = exp_sel && (addr_s2_q[12:0] == `BGR_OFS_EXP_LAMP);
    wire logic hit_ids_lo = per_sel && (addr_s2_q == `BGR_OFS_SLOT_IDS_LO);
    wire logic hit_ids_hi = per_sel && (addr_s2_q == `BGR_OFS_SLOT_IDS_HI);
    wire logic hit_slamps = per_sel && (addr_s2_q == `BGR_OFS_SLOT_LAMPS);
    wire logic hit_fabric = per_sel && (addr_s2_q == `BGR_OFS_FABRIC);
    wire logic hit_ver = glue_sel && (addr_s2_q[7:0] == `BGR_OFS_GLUE_VER);
    wire logic hit_cache = glue_sel && (addr_s2_q[7:0] == `BGR_OFS_CACHE_CTL);

    assign ids.slot0 = card_id(card_s2_q[16], card_s2_q[3:0]); // R5
    assign ids.slot1 = card_id(card_s2_q[17], card_s2_q[7:4]); // R5
    assign ids.slot2 = card_id(card_s2_q[18], card_s2_q[11:8]); // R5
    assign ids.slot3 = card_id(card_s2_q[19], card_s2_q[15:12]); // R5
    // id 0xE passes through unchanged; software fetches the long form
    wire logic [7:0] exp_id = exp_s2_q[8] ? `BGR_EXP_ABSENT : exp_s2_q[7:0]; // R1

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_exp_id) begin
            rd_mux = exp_id; // R1
        end else if (hit_exp_lamp) begin
            rd_mux = {6'h00, exp_lamp_q}; // R15
        end else if (hit_ids_lo) begin
            rd_mux = {ids.slot0, ids.slot1}; // R3
        end else if (hit_ids_hi) begin
            rd_mux = {ids.slot2, ids.slot3}; // R3
        end else if (hit_slamps) begin
            rd_mux = slot_lamp_q; // R6
        end else if (hit_fabric) begin
            rd_mux = 8'h00; // R7
        end else if (hit_ver) begin
            rd_mux = GLUE_VERSION; // R8
        end else if (hit_cache) begin
            rd_mux = {4'h0, cache_q}; // R15
        end
    end

    wire logic any_sel = exp_sel || per_sel || glue_sel;

    // a read cycle only; write data must never show on the read bus
    wire logic rd_cycle = rd_act && !wr_act;
    wire logic [7:0] rdata_d = rd_cycle ? rd_mux : 8'h00; // R16
    wire logic rd_oe_d = rd_cycle && any_sel; // R16

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wr_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_act;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            exp_lamp_q <= 2'(`BGR_LAMP_RST);
        end else if (wr_pulse && hit_exp_lamp) begin
            exp_lamp_q <= wdata_lamp(wdat_s2_q); // R2 R15
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            slot_lamp_q <= `BGR_LAMP_RST;
        end else if (wr_pulse && hit_slamps) begin
            slot_lamp_q <= wdat_s2_q; // R6
        end
    end

    // cache comes up with every control asserted, so it stays off until set up
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cache_q <= `BGR_CACHE_RST; // R10 R11 R12 R13
        end else if (wr_pulse && hit_cache) begin
            cache_q <= wdat_s2_q[3:0]; // R9 R15
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rd_oe_q <= 1'b0;
        end else begin
            rd_oe_q <= rd_oe_d;
        end
    end

    assign RDATA = rdata_q;
    assign RDATA_OE = rd_oe_q;

    assign cache_out.refill_block_n = cache_q[`BGR_CACHE_REFILL_BIT]; // R10
    assign cache_out.directory_wipe_n = cache_q[`BGR_CACHE_WIPE_BIT]; // R11
    assign cache_out.drain_n = cache_q[`BGR_CACHE_DRAIN_BIT]; // R12
    assign cache_out.force_bypass_n = cache_q[`BGR_CACHE_BYPASS_BIT]; // R13
    assign CACHE_REFILL_BLOCK_OUT_N = cache_out.refill_block_n; // R9
    assign CACHE_DIRECTORY_WIPE_OUT_N = cache_out.directory_wipe_n; // R9
    assign CACHE_DRAIN_OUT_N = cache_out.drain_n; // R9
    assign CACHE_FORCE_BYPASS_OUT_N = cache_out.force_bypass_n; // R9

    bgr_lamp_drv u_exp_lamp (
        .CLK_SYS(CLK_SYS),
        .RST_B(RST_B),
        .code(exp_lamp_q),
        .red(EXP_LAMP_RED),
        .green(EXP_LAMP_GREEN)
    ); // R2

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_slot
            // slot 3 sits in bits 1:0, so field index is 3 - slot
            bgr_lamp_drv u_lamp (
                .CLK_SYS(CLK_SYS),
                .RST_B(RST_B),
                .code(slot_lamp_q[2*(3-g) +: 2]),
                .red(SLOT_LAMP_RED[g]),
                .green(SLOT_LAMP_GREEN[g])
            ); // R6
        end
    endgenerate
endmodule

/* File: sim/bgr_glue_regs_props.sv */
`timescale 1ns/10ps
module bgr_props (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic EXPANSION_WINDOW_SELECT_N,
    input wire logic PERIPHERAL_WINDOW_SELECT_N,
    input wire logic GLUE_WINDOW_SELECT_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] RDATA,
    input wire logic RDATA_OE,
    input wire logic EXP_LAMP_RED,
    input wire logic EXP_LAMP_GREEN,
    input wire logic [3:0] SLOT_LAMP_RED,
    input wire logic [3:0] SLOT_LAMP_GREEN,
    input wire logic CACHE_REFILL_BLOCK_OUT_N,
    input wire logic CACHE_DIRECTORY_WIPE_OUT_N,
    input wire logic CACHE_DRAIN_OUT_N,
    input wire logic CACHE_FORCE_BYPASS_OUT_N
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    wire logic idle = EXPANSION_WINDOW_SELECT_N && PERIPHERAL_WINDOW_SELECT_N;
    wire logic quiet = idle && GLUE_WINDOW_SELECT_N;
    wire logic ctl_hit = !GLUE_WINDOW_SELECT_N && ADDR[7:0] == 8'h01;
    wire logic [3:0] cache = {CACHE_FORCE_BYPASS_OUT_N, CACHE_DRAIN_OUT_N,
        CACHE_DIRECTORY_WIPE_OUT_N, CACHE_REFILL_BLOCK_OUT_N};
    property p_oe; RDATA_OE |-> $past(!RD_N, 2) || $past(!RD_N, 3); endproperty
    a_oe: assert property (p_oe) else $error("drive without read");
    property p_idle; quiet [*4] |-> !RDATA_OE; endproperty
    a_idle: assert property (p_idle) else $error("drive while idle");
    property p_zero; !RDATA_OE |-> RDATA == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("data while not driving");
    property p_rw; RDATA_OE |-> $past(WR_N, 2); endproperty
    a_rw: assert property (p_rw) else $error("drive during write");
    property p_cache; !$stable(cache) |-> $past(!WR_N, 2) || $past(!WR_N, 3); endproperty
    a_cache: assert property (p_cache) else $error("cache change without write");
    property p_lamp; !(EXP_LAMP_RED && EXP_LAMP_GREEN); endproperty
    a_lamp: assert property (p_lamp) else $error("lamp red and green");
    property p_slot; (SLOT_LAMP_RED & SLOT_LAMP_GREEN) == 4'h0; endproperty
    a_slot: assert property (p_slot) else $error("slot lamp red and green");
    property p_hi; RDATA_OE && $past(ctl_hit, 2) |-> RDATA[7:4] == 4'h0; endproperty
    a_hi: assert property (p_hi) else $error("cache high bits set");
    c_read: cover property (RDATA_OE);
    c_on: cover property ($rose(CACHE_FORCE_BYPASS_OUT_N));
    c_green: cover property ($rose(EXP_LAMP_GREEN));
endmodule

bind bgr_glue_regs bgr_props i_props (.*);

/* File: sim/bgr_far_model.sv */
`timescale 1ns/10ps
module bgr_far_model (
    input wire logic [4:0] fit,
    output logic EXP_MODULE_PRESENT_N,
    output logic [7:0] EXP_MODULE_ID,
    output logic [3:0] CARD_PRESENT_N,
    output logic [15:0] CARD_IDS
);
    // empty sockets float, so their id lines must not look like all ones
    assign EXP_MODULE_PRESENT_N = !fit[4];
    assign EXP_MODULE_ID = fit[4] ? 8'h5a : 8'h3c;
    assign CARD_PRESENT_N = ~fit[3:0];
    assign CARD_IDS = {fit[3] ? 4'hc : 4'h6, fit[2] ? 4'h7 : 4'h6,
        fit[1] ? 4'he : 4'h6, fit[0] ? 4'h3 : 4'h6};
endmodule

/* File: sim/board_glue_register_decoder_tb.sv */
`timescale 1ns/10ps
module board_glue_register_decoder_tb;
    logic CLK_SYS = 1'h0;
    logic RST_B = 1'h0;
    logic EXPANSION_WINDOW_SELECT_N = 1'h1;
    logic PERIPHERAL_WINDOW_SELECT_N = 1'h1;
    logic GLUE_WINDOW_SELECT_N = 1'h1;
    logic RD_N = 1'h1;
    logic WR_N = 1'h1;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0] WDATA = 8'h00;
    logic [4:0] fit = 5'h1b;
    logic [7:0] RDATA, EXP_MODULE_ID, q;
    logic RDATA_OE, EXP_MODULE_PRESENT_N, EXP_LAMP_RED, EXP_LAMP_GREEN;
    logic [3:0] SLOT_LAMP_RED, SLOT_LAMP_GREEN, CARD_PRESENT_N;
    logic [15:0] CARD_IDS;
    logic CACHE_REFILL_BLOCK_OUT_N, CACHE_DIRECTORY_WIPE_OUT_N;
    logic CACHE_DRAIN_OUT_N, CACHE_FORCE_BYPASS_OUT_N;
    int failures = 0;
    int comparisons = 0;
    wire logic [7:0] cache = {4'h0, CACHE_FORCE_BYPASS_OUT_N, CACHE_DRAIN_OUT_N,
        CACHE_DIRECTORY_WIPE_OUT_N, CACHE_REFILL_BLOCK_OUT_N};
    wire logic [7:0] lamp = {6'h00, EXP_LAMP_GREEN, EXP_LAMP_RED};
    wire logic [7:0] slamp = {SLOT_LAMP_GREEN, SLOT_LAMP_RED};
    bgr_glue_regs i_dut (.*);
    bgr_far_model i_far (.*);
    always #5 CLK_SYS = ~CLK_SYS;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // held well past the two-flop input synchroniser, then a long gap
    task automatic xfer(input logic [2:0] w, input logic [15:0] a, input logic [7:0] d,
        input logic rd);
        {EXPANSION_WINDOW_SELECT_N, PERIPHERAL_WINDOW_SELECT_N, GLUE_WINDOW_SELECT_N} <= ~w;
        ADDR <= a;
        WDATA <= d;
        RD_N <= !rd;
        WR_N <= rd;
        repeat (6) @(posedge CLK_SYS);
        #1 q = RDATA;
        @(posedge CLK_SYS);
        {EXPANSION_WINDOW_SELECT_N, PERIPHERAL_WINDOW_SELECT_N, GLUE_WINDOW_SELECT_N} <= 3'h7;
        RD_N <= 1'h1;
        WR_N <= 1'h1;
        repeat (5) @(posedge CLK_SYS);
    endtask
    task automatic t_cache;
        chk("cache reset", cache, 8'h00);
        xfer(3'h1, 16'h0000, 8'h00, 1'h1);
        chk("version", q, 8'h01);
        // cache enabled only once the processor side is set up
        xfer(3'h1, 16'h0001, 8'h05, 1'h0);
        chk("cache split", cache, 8'h05);
        xfer(3'h1, 16'h0001, 8'hff, 1'h0);
        xfer(3'h1, 16'h0001, 8'h00, 1'h1);
        chk("cache read", q, 8'h0f);
        chk("cache on", cache, 8'h0f);
        $display("cache test done");
    endtask
    task automatic t_exp;
        xfer(3'h4, 16'h0000, 8'h00, 1'h1);
        chk("module id", q, 8'h5a);
        for (int c = 0; c < 4; c++) begin
            xfer(3'h4, 16'h0002, 8'hfc | 8'(c), 1'h0);
            xfer(3'h4, 16'h0002, 8'h00, 1'h1);
            chk("lamp read", q, 8'(c));
            chk("lamp", lamp, (c == 1) ? 8'h01 : (c == 2) ? 8'h02 : 8'h00);
        end
        fit[4] <= 1'h0;
        xfer(3'h4, 16'h0000, 8'h00, 1'h1);
        chk("no module", q, 8'hff);
        $display("expansion test done");
    endtask
    task automatic t_slots;
        xfer(3'h2, 16'h0000, 8'h00, 1'h1);
        chk("ids low", q, 8'h3e);
        xfer(3'h2, 16'h1000, 8'h00, 1'h1);
        chk("ids high", q, 8'hfc);
        xfer(3'h2, 16'h2000, 8'h9c, 1'h0);
        chk("slot lamps", slamp, 8'h12);
        xfer(3'h2, 16'h2000, 8'h00, 1'h1);
        chk("slot lamp read", q, 8'h9c);
        xfer(3'h2, 16'h3000, 8'h55, 1'h0);
        xfer(3'h2, 16'h3000, 8'h00, 1'h1);
        chk("reserved", q, 8'h00);
        xfer(3'h0, 16'h2000, 8'h00, 1'h1);
        chk("no select", q, 8'h00);
        $display("slot test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK_SYS);
        RST_B <= 1'h1;
        @(posedge CLK_SYS);
        t_cache();
        t_exp();
        t_slots();
        end_of_test();
    end
endmodule
